/* File: src/asr_top.sv */
// async serial unit: axi4-lite registers, receiver, transmitter
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module asr_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        rxd,
  output logic             txd
);
  import asr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic       awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic       aw_got_reg, w_got_reg;
  logic [3:0] aw_addr_reg, rd_addr_reg;
  logic [7:0] wbyte_reg;
  logic       wen_reg;
  logic [7:0] ctl1_reg, ctl2_reg, rx_buf_reg, tx_buf_reg;
  logic       full_reg, ovr_reg, noise_reg, frame_reg, txe_reg, tc_reg;
  logic       arm_full_reg, arm_ovr_reg, arm_noise_reg, arm_frame_reg;
  logic       rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_in_reg;
  logic [8:0] tick_cnt_reg;
  logic       tick;
  asr_rx_t    rx_st_reg;
  logic [3:0] rx_sc_reg, rx_bit_reg;
  logic [1:0] samp_reg;
  logic [8:0] rx_sh_reg;
  logic       rx_nz_reg;
  logic       tx_busy_reg;
  logic [3:0] tx_sc_reg, tx_left_reg;
  logic [10:0] tx_sh_reg;
  logic       txd_reg;

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign txd = txd_reg;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == OFS_DATA) || (a == OFS_CTL1) || (a == OFS_STAT) ||
             (a == OFS_CTL2);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes and register side effects
  logic aw_hs, w_hs, wr_do, ar_hs, stat_rd, data_rd, data_wr;
  assign aw_hs = awvalid & awready_reg;
  assign w_hs = wvalid & wready_reg;
  assign wr_do = aw_got_reg & w_got_reg & ~bvalid_reg;
  assign ar_hs = arvalid & arready_reg;
  assign stat_rd = ar_hs & (araddr == OFS_STAT);
  assign data_rd = ar_hs & (araddr == OFS_DATA);
  assign data_wr = wr_do & wen_reg & (aw_addr_reg == OFS_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      wbyte_reg <= 8'h00;
      wen_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OK;
    end else if (ce) begin
      awready_reg <= ~(aw_hs | (aw_got_reg & ~wr_do));
      wready_reg <= ~(w_hs | (w_got_reg & ~wr_do));
      if (aw_hs) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (wr_do) begin
        aw_got_reg <= 1'b0;
      end
      if (w_hs) begin
        w_got_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wen_reg <= wstrb[0];
      end else if (wr_do) begin
        w_got_reg <= 1'b0;
      end
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_addr_reg) ? RESP_OK : RESP_ERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OK;
      rdata_reg <= 32'h0000_0000;
      rd_addr_reg <= 4'h0;
    end else if (ce) begin
      arready_reg <= ~(ar_hs | (rvalid_reg & ~rready));
      if (ar_hs) begin
        rvalid_reg <= 1'b1;
        rd_addr_reg <= araddr;
        rresp_reg <= mapped(araddr) ? RESP_OK : RESP_ERR;
        unique case (araddr)
          OFS_DATA: rdata_reg <= {24'h00_0000, rx_buf_reg};
          OFS_CTL1: rdata_reg <= {24'h00_0000, ctl1_reg & CTL1_MASK};
          OFS_STAT: rdata_reg <= {24'h00_0000, txe_reg, tc_reg, full_reg,
                                  1'b0, ovr_reg, noise_reg, frame_reg, 1'b0};
          OFS_CTL2: rdata_reg <= {24'h00_0000, ctl2_reg};
          default:  rdata_reg <= 32'h0000_0000;
        endcase
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and sample tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
      rx_in_reg <= 1'b1;
      tick_cnt_reg <= 9'h000;
    end else if (ce) begin
      rx_s1_reg <= rxd;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg) begin
        rx_in_reg <= rx_s3_reg;
      end
      tick_cnt_reg <= tick ? 9'h000 : tick_cnt_reg + 9'h001;
    end
  end
  assign tick = (tick_cnt_reg == 9'(TICK_CYC - 1));

  ////////////////////////////////////////////////////////////////////////
  // receiver
  logic nine, bit_val, bit_nz, at_mid, last_bit, xfer, mark_wake;
  logic sleep_set_sw;
  assign nine = ctl1_reg[C1_SIZE];
  assign at_mid = tick & (rx_sc_reg == SAMP_MID);
  assign bit_val = maj3(samp_reg[1], samp_reg[0], rx_in_reg);
  assign bit_nz = ~((samp_reg[1] == samp_reg[0]) & (samp_reg[0] == rx_in_reg));
  assign last_bit = (rx_bit_reg == (nine ? 4'h8 : 4'h7));
  assign xfer = (rx_st_reg == RX_STOP) & at_mid;
  // msb of the character decides address vs data
  assign mark_wake = (rx_st_reg == RX_DATA) & at_mid & last_bit & bit_val &
                     ctl1_reg[C1_WAKE] & ctl2_reg[C2_SLEEP];
  assign sleep_set_sw = wr_do & wen_reg & (aw_addr_reg == OFS_CTL2);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_reg <= RX_IDLE;
      rx_sc_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      samp_reg <= 2'b11;
      rx_sh_reg <= 9'h000;
      rx_nz_reg <= 1'b0;
    end else if (ce) begin
      if (tick && (rx_sc_reg == 4'h7 || rx_sc_reg == 4'h8)) begin
        samp_reg <= {samp_reg[0], rx_in_reg};
      end
      if (rx_st_reg != RX_IDLE && tick) begin
        rx_sc_reg <= rx_sc_reg + 4'h1;
      end
      unique case (rx_st_reg)
        RX_IDLE: begin
          rx_sc_reg <= 4'h0;
          rx_bit_reg <= 4'h0;
          rx_nz_reg <= 1'b0;
          if (!rx_in_reg && ctl2_reg[C2_RXEN]) begin
            rx_st_reg <= RX_START;
          end
        end
        RX_START: begin
          if (at_mid) begin
            rx_nz_reg <= bit_nz;
            if (bit_val) begin
              rx_st_reg <= RX_IDLE;
            end
          end
          if (tick && rx_sc_reg == SAMP_END) begin
            rx_st_reg <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (at_mid) begin
            rx_sh_reg <= {bit_val, rx_sh_reg[8:1]};
            rx_nz_reg <= rx_nz_reg | bit_nz;
          end
          if (tick && rx_sc_reg == SAMP_END) begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (last_bit) begin
              rx_st_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (at_mid) begin
            rx_st_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive buffer and flags; a new event wins over the read clear
  logic sleeping, stop_ok, rx_nz_all, load_ok, ovr_set;
  logic [7:0] rx_byte;
  assign sleeping = ctl2_reg[C2_SLEEP];
  assign stop_ok = bit_val;
  assign rx_nz_all = rx_nz_reg | bit_nz;
  // nine-bit frames sit shifted one place lower
  assign rx_byte = nine ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
  assign ovr_set = xfer & ~sleeping & full_reg;
  assign load_ok = xfer & ~sleeping & ~full_reg & ~frame_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_reg <= 8'h00;
      full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      noise_reg <= 1'b0;
      frame_reg <= 1'b0;
      arm_full_reg <= 1'b0;
      arm_ovr_reg <= 1'b0;
      arm_noise_reg <= 1'b0;
      arm_frame_reg <= 1'b0;
    end else if (ce) begin
      if (stat_rd) begin
        arm_full_reg <= full_reg;
        arm_ovr_reg <= ovr_reg;
        arm_noise_reg <= noise_reg;
        arm_frame_reg <= frame_reg;
      end else if (data_rd) begin
        arm_full_reg <= 1'b0;
        arm_ovr_reg <= 1'b0;
        arm_noise_reg <= 1'b0;
        arm_frame_reg <= 1'b0;
      end
      if (load_ok) begin
        rx_buf_reg <= rx_byte;
        full_reg <= 1'b1;
        noise_reg <= rx_nz_all;
        frame_reg <= ~stop_ok;
      end else if (data_rd) begin
        if (arm_full_reg) full_reg <= 1'b0;
        if (arm_noise_reg) noise_reg <= 1'b0;
        if (arm_frame_reg) frame_reg <= 1'b0;
      end
      if (ovr_set) begin
        ovr_reg <= 1'b1;
      end else if (data_rd && arm_ovr_reg) begin
        ovr_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl1_reg <= CTL1_RST;
      ctl2_reg <= CTL2_RST;
    end else if (ce) begin
      if (wr_do && wen_reg && aw_addr_reg == OFS_CTL1) begin
        ctl1_reg[C1_TX9] <= wbyte_reg[C1_TX9];
        ctl1_reg[C1_SIZE] <= wbyte_reg[C1_SIZE];
        ctl1_reg[C1_WAKE] <= wbyte_reg[C1_WAKE];
      end
      if (load_ok && nine) begin
        ctl1_reg[C1_RX9] <= rx_sh_reg[8];
      end
      if (mark_wake) begin
        ctl2_reg[C2_SLEEP] <= 1'b0;
      end else if (sleep_set_sw) begin
        ctl2_reg[C2_SLEEP] <= wbyte_reg[C2_SLEEP];
      end
      if (sleep_set_sw) begin
        ctl2_reg[C2_TXEN] <= wbyte_reg[C2_TXEN];
        ctl2_reg[C2_RXEN] <= wbyte_reg[C2_RXEN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter: holding buffer plus shifter
  logic tx_load;
  assign tx_load = ~tx_busy_reg & ~txe_reg & ctl2_reg[C2_TXEN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_reg <= 8'h00;
      txe_reg <= 1'b1;
      tc_reg <= 1'b1;
      tx_busy_reg <= 1'b0;
      tx_sc_reg <= 4'h0;
      tx_left_reg <= 4'h0;
      tx_sh_reg <= 11'h7FF;
      txd_reg <= 1'b1;
    end else if (ce) begin
      if (data_wr) begin
        tx_buf_reg <= wbyte_reg;
        txe_reg <= 1'b0;
        tc_reg <= 1'b0;
      end else if (tx_load) begin
        txe_reg <= 1'b1;
      end
      if (tx_load) begin
        tx_busy_reg <= 1'b1;
        tx_sc_reg <= 4'h0;
        tx_left_reg <= nine ? TX_BITS9 : TX_BITS8;
        tx_sh_reg <= {1'b1, ~nine | ctl1_reg[C1_TX9], tx_buf_reg,
                      1'b0};
      end else if (tx_busy_reg && tick) begin
        tx_sc_reg <= tx_sc_reg + 4'h1;
        if (tx_sc_reg == 4'h0) begin
          txd_reg <= tx_sh_reg[0];
        end
        if (tx_sc_reg == SAMP_END) begin
          tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
          tx_left_reg <= tx_left_reg - 4'h1;
          if (tx_left_reg == 4'h1) begin
            tx_busy_reg <= 1'b0;
            if (txe_reg && !data_wr) tc_reg <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence ovr_clear_s;
    ce && data_rd && arm_ovr_reg && !ovr_set;
  endsequence
  sequence frame_clear_s;
    ce && data_rd && arm_frame_reg && !load_ok;
  endsequence

  overrun_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ovr_set |=> ovr_reg && $stable(rx_buf_reg))
    else $error("overrun did not set or buffer changed");
  overrun_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ovr_set && !frame_reg && !data_rd |=> !frame_reg)
    else $error("framing reported with overrun");
  sleep_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && xfer && sleeping && !data_rd
      |=> $stable({full_reg, ovr_reg, noise_reg, frame_reg}))
    else $error("flag moved while asleep");
  mark_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mark_wake |=> !ctl2_reg[C2_SLEEP] && (rx_st_reg == RX_DATA))
    else $error("address mark did not wake before stop");
  frame_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && load_ok && !stop_ok |=> frame_reg && full_reg)
    else $error("framing flag not set with full flag");
  frame_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_reg && xfer |=> $stable(rx_buf_reg))
    else $error("buffer loaded while framing flag set");
  noise_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    noise_reg |-> full_reg)
    else $error("noise flag without full flag");
  ovr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ovr_clear_s |=> !ovr_reg)
    else $error("overrun not cleared by read sequence");
  frame_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_clear_s |=> !frame_reg)
    else $error("framing not cleared by read sequence");
  ctl1_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_reg && rd_addr_reg == OFS_CTL1 |-> rdata_reg[5] == 1'b0
      && rdata_reg[2:0] == 3'b000)
    else $error("unimplemented control bits read nonzero");
endmodule
`default_nettype wire

/* File: src/asr_pkg.sv */
// constants and register map for the async serial receiver/transmitter
// What this block does
// - address mark: 7 info bits (8 when nine-bit) plus MSB marking address
// - receiver_sleep set suppresses every receiver status flag
// - an address-mark character clears receiver_sleep by hardware
// - receiver_sleep clears before that character's stop bit arrives
// - overrun_flag sets when a byte completes while rx_full_flag is set
// - overrun drops the new byte, buffer keeps the old one
// - overrun_flag clears on status read (flag set) then data read
// - noise on any bit sets noise_flag, never before rx_full_flag
// - noise_flag clears on status read (flag set) then data read
// - missing stop bit sets framing_flag together with rx_full_flag
// - framing plus overrun on one byte reports only the overrun
// - framing_flag set blocks further loads into the receive buffer
// - framing_flag clears on status read (flag set) then data read
// - one data address: read receive buffer, write transmit buffer
// - nine-bit mode stores ninth received bit in rx_ninth_bit
// - nine-bit mode sends tx_ninth_bit as ninth transmitted bit
// - char_size_select 0: 8 data bits, 1: 9 data bits, one stop
// - rouse_select 1 address-mark wakeup; 0 no hardware wakeup, receiver_sleep clears only by software write
// - control one bit 5 and bits 2..0 read as zero
package asr_pkg;
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_CTL1 = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_CTL2 = 4'hC;
  // control one fields
  localparam int C1_RX9 = 7;
  localparam int C1_TX9 = 6;
  localparam int C1_SIZE = 4;
  localparam int C1_WAKE = 3;
  localparam logic [7:0] CTL1_MASK = 8'hD8;
  // status fields
  localparam int ST_TXE = 7;
  localparam int ST_TC = 6;
  localparam int ST_FULL = 5;
  localparam int ST_OVR = 3;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAME = 1;
  // control two fields
  localparam int C2_TXEN = 3;
  localparam int C2_RXEN = 2;
  localparam int C2_SLEEP = 1;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  // bit timing: 16 samples per bit
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_HZ = 625_000;
  localparam int OVERSAMPLE = 16;
  localparam int TICK_CYC = CLK_HZ / (BAUD_HZ * OVERSAMPLE);
  localparam logic [3:0] SAMP_MID = 4'h9;
  localparam logic [3:0] SAMP_END = 4'hF;
  localparam logic [3:0] TX_BITS8 = 4'hA;
  localparam logic [3:0] TX_BITS9 = 4'hB;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_t;
endpackage

/* File: tb/asr_node_model.sv */
// behavioural far-side serial node: sends and captures frames
`timescale 1ns/1ps
`default_nettype none
module asr_node_model
  import asr_pkg::*;
(
  input  wire logic aclk,
  output logic      line_out,
  input  wire logic line_in
);
  import asr_pkg::*;
  localparam int BIT_CYC = TICK_CYC * OVERSAMPLE;
  localparam int EDGE_CYC = BIT_CYC / 2 - TICK_CYC / 2;

  initial line_out = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // one bit time; a glitch one tick wide hits exactly one mid-bit sample
  task automatic hold_bit(input logic v, input logic glitch);
    if (glitch) begin
      line_out <= v;
      repeat (EDGE_CYC) @(posedge aclk);
      line_out <= ~v;
      repeat (TICK_CYC) @(posedge aclk);
      line_out <= v;
      repeat (BIT_CYC - EDGE_CYC - TICK_CYC) @(posedge aclk);
    end else begin
      line_out <= v;
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // start, 8 or 9 data bits lsb first, stop; line back to idle mark
  task automatic send_char(input logic [8:0] ch, input logic nine,
                           input logic good_stop, input int noise_bit);
    int nbits;
    nbits = nine ? 9 : 8;
    hold_bit(1'b0, 1'b0);
    for (int i = 0; i < nbits; i++) begin
      hold_bit(ch[i], i == noise_bit);
    end
    hold_bit(good_stop, 1'b0);
    line_out <= 1'b1;
    // one idle bit so a low stop cannot merge into the next start
    repeat (BIT_CYC) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // capture one frame from the unit's transmit line at mid-bit
  task automatic recv_char(input logic nine, output logic [8:0] ch,
                           output logic stop_bit);
    ch = 9'h000;
    do @(posedge aclk); while (line_in !== 1'b0);
    repeat (BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BIT_CYC) @(posedge aclk);
      ch[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge aclk);
    stop_bit = line_in;
  endtask
endmodule
`default_nettype wire

/* File: tb/async_serial_rx_wakeup_errors_tb.sv */
// testbench: register access, receive errors, wakeup, transmit
`timescale 1ns/1ps
`default_nettype none
module async_serial_rx_wakeup_errors_tb;
  import asr_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic        ce;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  wire         rxd;
  wire         txd;
  int          err_count;
  int          total_checks;
  logic [31:0] d;
  logic [1:0]  r;
  logic [1:0]  wr_resp;
  logic [8:0]  ch;
  logic        sb;

  asr_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd(rxd), .txd(txd));

  asr_node_model node (.aclk(aclk), .line_out(rxd), .line_in(txd));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite master: hold each channel until its own handshake
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] v);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] dv,
                        output logic [1:0] rv);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    dv = rdata;
    rv = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] dv;
    logic [1:0]  rv;
    axi_rd(a, dv, rv);
    chk(dv, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // about 40,000 cycles; the tests need roughly 6,600
  initial begin
    #1_000_000;
    err_count++;
    test_done;
  end

  initial begin
    err_count = 0;
    total_checks = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    awaddr = 4'h0;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 4'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset values, read-only and unimplemented bits, unmapped place
    rd_chk(OFS_CTL1, 32'h0000_0000);
    rd_chk(OFS_STAT, 32'h0000_00C0);
    axi_rd(4'h2, d, r);
    chk(32'(r), 32'(RESP_ERR));
    chk(d, 32'h0000_0000);
    axi_wr(4'h2, 8'h00);
    chk(32'(wr_resp), 32'(RESP_ERR));
    axi_wr(OFS_CTL1, 8'hFF);
    chk(32'(wr_resp), 32'(RESP_OK));
    rd_chk(OFS_CTL1, 32'h0000_0058);
    axi_wr(OFS_CTL1, 8'h00);
    axi_wr(OFS_CTL2, 8'h04);
    // plain reception
    node.send_char(9'h05A, 1'b0, 1'b1, -1);
    rd_chk(OFS_STAT, 32'h0000_00E0);
    rd_chk(OFS_DATA, 32'h0000_005A);
    rd_chk(OFS_STAT, 32'h0000_00C0);
    // second byte arrives with the buffer still full
    node.send_char(9'h011, 1'b0, 1'b1, -1);
    node.send_char(9'h022, 1'b0, 1'b0, -1);
    rd_chk(OFS_STAT, 32'h0000_00E8);
    rd_chk(OFS_DATA, 32'h0000_0011);
    rd_chk(OFS_STAT, 32'h0000_00C0);
    // one sample disturbed in data bit 3
    node.send_char(9'h066, 1'b0, 1'b1, 3);
    rd_chk(OFS_STAT, 32'h0000_00E4);
    rd_chk(OFS_DATA, 32'h0000_0066);
    rd_chk(OFS_STAT, 32'h0000_00C0);
    // stop bit held low
    node.send_char(9'h033, 1'b0, 1'b0, -1);
    rd_chk(OFS_STAT, 32'h0000_00E2);
    // next byte while framing is pending is kept out of the buffer
    node.send_char(9'h044, 1'b0, 1'b1, -1);
    rd_chk(OFS_STAT, 32'h0000_00EA);
    rd_chk(OFS_DATA, 32'h0000_0033);
    rd_chk(OFS_STAT, 32'h0000_00C0);
    // nine-bit address-mark wakeup
    axi_wr(OFS_CTL1, 8'h18);
    axi_wr(OFS_CTL2, 8'h06);
    node.send_char(9'h0AB, 1'b1, 1'b1, -1);
    rd_chk(OFS_STAT, 32'h0000_00C0);
    rd_chk(OFS_CTL2, 32'h0000_0006);
    node.send_char(9'h1C5, 1'b1, 1'b1, -1);
    rd_chk(OFS_CTL2, 32'h0000_0004);
    rd_chk(OFS_STAT, 32'h0000_00E0);
    rd_chk(OFS_CTL1, 32'h0000_0098);
    rd_chk(OFS_DATA, 32'h0000_00C5);
    // nine-bit transmit with the ninth bit set
    axi_wr(OFS_CTL1, 8'h58);
    axi_wr(OFS_CTL2, 8'h0C);
    fork
      node.recv_char(1'b1, ch, sb);
      axi_wr(OFS_DATA, 8'hA5);
    join
    chk(32'(ch), 32'h0000_01A5);
    chk(32'(sb), 32'h0000_0001);
    test_done;
  end
endmodule
`default_nettype wire
